// file: rtl/alu_consts.vh
// Purpose: Shared constants of the 2-bit micro-function slice datapath.
// Assumes: Included by bare name from the design files under rtl/.
// Notes: Definitions only; the guard keeps a second inclusion harmless.
`ifndef ALU_CONSTS_VH
`define ALU_CONSTS_VH

// Slice and bus widths.
`define WORD_W 2
`define FUNC_W 7
`define FGRP_W 3
`define RGRP_W 4
`define FGRP_HI 6
`define FGRP_LO 4
`define RGRP_HI 3
`define RGRP_LO 0

// Register file: ten scratchpad words, the holding word and the working word.
`define FILE_DEPTH 12
`define IDX_W 4
`define IDX_HOLD 4'hA
`define IDX_WORK 4'hB
`define WORD_RESET 2'h0
`define WORD_ZERO 2'h0
`define WORD_ONES 2'h3
`define CARRY_RESET 1'b0

// Operation groups carried in the upper bits of the function bus.
`define FG_0 3'h0
`define FG_1 3'h1
`define FG_2 3'h2
`define FG_3 3'h3
`define FG_4 3'h4
`define FG_5 3'h5

// Register-selection codes carried in the lower bits of the function bus.
`define RSEL_GRP1_LAST 4'hB
`define RSEL_GRP2_WORK 4'hC
`define RSEL_GRP2_HOLD 4'hD
`define RSEL_GRP3_WORK 4'hE
`define RSEL_GRP3_HOLD 4'hF

// Register group classes derived from the selection code.
`define RCLS_ONE 2'h1
`define RCLS_TWO 2'h2
`define RCLS_THREE 2'h3

`endif

// file: rtl/bit_slice_alu.v
// Purpose: Micro-function datapath of a 2-bit bit-slice processing element, groups 1 to 5.
// Assumes: Function bus, mask, carry and data buses come from logic on ref_clk.
// Notes: Groups 0, 6 and 7 hold every register and pass carry_in to carry_out.
// Group 1 with a group I or II selection code is refused in the same way.
// Selection codes 0 to 9 name scratchpad words, 10 the holding word and 11 the working word.
// Codes 12 and 13 name the working and holding word, with the memory bus as operand in groups 3 to 5.
// Codes 14 and 15 name the working and holding word, with the input bus as operand in groups 2 to 4.
// AT stands for the working or holding word that the selection code names.
// The registered carry_out reaches a neighbouring slice one clock later.
// Reset clears every word and carry_out at once, without waiting for a clock.
// A low clk_en freezes every word and carry_out.
`include "alu_consts.vh"

module bit_slice_alu (
   // Clock, reset and clock enable
   input wire ref_clk,
   input wire rst,
   input wire clk_en,
   // Micro-function control from the control unit
   input wire [`FUNC_W-1:0] func_bus,
   input wire [`WORD_W-1:0] k_bus,
   input wire carry_in,
   // Data inputs
   input wire [`WORD_W-1:0] mem_bus,
   input wire [`WORD_W-1:0] input_bus,
   // Registered results
   output wire [`WORD_W-1:0] working_sum,
   output wire [`WORD_W-1:0] holding_word,
   output reg carry_out
);

   // Register file: scratchpad words, then holding, then working word.
   reg [`WORD_W-1:0] file_reg [0:`FILE_DEPTH-1];

   // Decoded fields of the function bus.
   wire [`FGRP_W-1:0] op_group;
   wire [`RGRP_W-1:0] reg_sel;
   reg [1:0] reg_class;
   reg [`IDX_W-1:0] at_idx;

   // Operand views.
   wire [`IDX_W-1:0] scratch_idx;
   wire [`WORD_W-1:0] work_word;
   wire [`WORD_W-1:0] scratch_word;
   wire [`WORD_W-1:0] at_word;
   wire [`WORD_W-1:0] masked_work;

   // Adder connections.
   reg [`WORD_W-1:0] add_a;
   reg [`WORD_W-1:0] add_b;
   wire [`WORD_W-1:0] add_sum;
   wire add_carry;

   // Next-state decisions.
   reg write_en_next;
   reg [`IDX_W-1:0] dest_idx_next;
   reg [`WORD_W-1:0] dest_word_next;
   reg carry_out_next;
   reg [`WORD_W-1:0] logic_word;
   reg use_adder;
   reg use_logic;
   wire result_nonzero;

   integer i;

   assign op_group = func_bus[`FGRP_HI:`FGRP_LO];
   assign reg_sel = func_bus[`RGRP_HI:`RGRP_LO];

   assign work_word = file_reg[`IDX_WORK];
   assign scratch_word = file_reg[scratch_idx];
   assign at_word = file_reg[at_idx];
   assign masked_work = work_word & k_bus;

   // Codes past the last file word would read outside the file, so they fall back to the working word.
   assign scratch_idx = (reg_sel <= `RSEL_GRP1_LAST) ? reg_sel : `IDX_WORK;

   // Word-wise OR of the logic result, the zero test of groups 4 and 5.
   assign result_nonzero = |logic_word;

   assign working_sum = file_reg[`IDX_WORK];
   assign holding_word = file_reg[`IDX_HOLD];

   always @* begin
      reg_class = `RCLS_ONE;
      at_idx = `IDX_WORK;
      case (reg_sel)
         `RSEL_GRP2_WORK: begin
            reg_class = `RCLS_TWO;
            at_idx = `IDX_WORK;
         end
         `RSEL_GRP2_HOLD: begin
            reg_class = `RCLS_TWO;
            at_idx = `IDX_HOLD;
         end
         `RSEL_GRP3_WORK: begin
            reg_class = `RCLS_THREE;
            at_idx = `IDX_WORK;
         end
         `RSEL_GRP3_HOLD: begin
            reg_class = `RCLS_THREE;
            at_idx = `IDX_HOLD;
         end
         default: begin
            reg_class = `RCLS_ONE;
            at_idx = `IDX_WORK;
         end
      endcase
   end

   slice_adder u_adder (
      .addend_a(add_a),
      .addend_b(add_b),
      .carry_in(carry_in),
      .sum(add_sum),
      .carry_out(add_carry)
   );

   // Destination word: group I codes name a file word, the other codes name AT.
   always @* begin
      dest_idx_next = at_idx;
      case (op_group)
         `FG_2: begin
            if (reg_class == `RCLS_ONE) begin
               dest_idx_next = reg_sel;
            end
         end
         `FG_3: begin
            if (reg_class == `RCLS_ONE) begin
               dest_idx_next = reg_sel;
            end
         end
         `FG_4: begin
            if (reg_class == `RCLS_ONE) begin
               dest_idx_next = reg_sel;
            end
         end
         `FG_5: begin
            if (reg_class == `RCLS_ONE) begin
               dest_idx_next = reg_sel;
            end
         end
         default: begin
            dest_idx_next = at_idx;
         end
      endcase
   end

   // Adder operands for the arithmetic groups 1 to 3.
   always @* begin
      add_a = `WORD_ZERO;
      add_b = `WORD_ZERO;
      use_adder = 1'b0;
      case (op_group)
         `FG_1: begin
            if (reg_class == `RCLS_THREE) begin
               add_a = ~at_word | k_bus;
               add_b = at_word & k_bus;
               use_adder = 1'b1;
            end
         end
         `FG_2: begin
            add_b = `WORD_ONES;
            use_adder = 1'b1;
            if (reg_class == `RCLS_THREE) begin
               add_a = input_bus & k_bus;
            end else begin
               // mask 00 gives carry minus one
               add_a = masked_work;
            end
         end
         `FG_3: begin
            use_adder = 1'b1;
            if (reg_class == `RCLS_ONE) begin
               add_a = scratch_word;
               add_b = masked_work;
            end else if (reg_class == `RCLS_TWO) begin
               add_a = mem_bus;
               add_b = masked_work;
            end else begin
               add_a = at_word;
               add_b = input_bus & k_bus;
            end
         end
         default: begin
            use_adder = 1'b0;
         end
      endcase
   end

   // Masked AND results for the logic groups 4 and 5.
   always @* begin
      logic_word = `WORD_ZERO;
      use_logic = 1'b0;
      case (op_group)
         `FG_4: begin
            use_logic = 1'b1;
            if (reg_class == `RCLS_ONE) begin
               logic_word = scratch_word & masked_work;
            end else if (reg_class == `RCLS_TWO) begin
               logic_word = mem_bus & masked_work;
            end else begin
               logic_word = at_word & input_bus & k_bus;
            end
         end
         `FG_5: begin
            use_logic = 1'b1;
            if (reg_class == `RCLS_ONE) begin
               logic_word = k_bus & scratch_word;
            end else if (reg_class == `RCLS_TWO) begin
               logic_word = k_bus & mem_bus;
            end else begin
               // Group 5 with a group III code masks AT.
               logic_word = k_bus & at_word;
            end
         end
         default: begin
            use_logic = 1'b0;
         end
      endcase
   end

   // Result and carry selection.
   always @* begin
      write_en_next = 1'b0;
      dest_word_next = `WORD_ZERO;
      carry_out_next = carry_in;
      if (use_adder) begin
         write_en_next = 1'b1;
         dest_word_next = add_sum;
         carry_out_next = add_carry;
      end else if (use_logic) begin
         write_en_next = 1'b1;
         dest_word_next = logic_word;
         carry_out_next = carry_in | result_nonzero;
      end
   end

   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         for (i = 0; i < `FILE_DEPTH; i = i + 1) begin
            file_reg[i] <= `WORD_RESET;
         end
      end else if (clk_en) begin
         if (write_en_next) begin
            file_reg[dest_idx_next] <= dest_word_next;
         end
      end
   end

   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         carry_out <= `CARRY_RESET;
      end else if (clk_en) begin
         carry_out <= carry_out_next;
      end
   end

endmodule // bit_slice_alu

// file: rtl/slice_adder.v
// Purpose: Two-operand adder with carry in and carry out for one slice word.
// Assumes: Purely combinational; the caller registers the results.
// Notes: Carry out is the bit above the word and chains to the next slice.
`include "alu_consts.vh"

module slice_adder (
   // Operands
   input wire [`WORD_W-1:0] addend_a,
   input wire [`WORD_W-1:0] addend_b,
   input wire carry_in,
   // Result
   output wire [`WORD_W-1:0] sum,
   output wire carry_out
);

   wire [`WORD_W:0] full_sum;

   assign full_sum = {1'b0, addend_a} + {1'b0, addend_b} + {{`WORD_W{1'b0}}, carry_in};
   assign sum = full_sum[`WORD_W-1:0];
   assign carry_out = full_sum[`WORD_W];

endmodule // slice_adder

// file: test/alu_checks_props.sv
// Purpose: Port assertions for bit_slice_alu.
// Assumes: Sees only the top-level ports.
// Notes: The bind follows the module.
module alu_checks (
   // Clock and control
   input wire ref_clk,
   input wire rst,
   input wire clk_en,
   input wire [6:0] func_bus,
   input wire [1:0] k_bus,
   input wire carry_in,
   // Data and results
   input wire [1:0] mem_bus,
   input wire [1:0] input_bus,
   input wire [1:0] working_sum,
   input wire [1:0] holding_word,
   input wire carry_out
);
   timeunit 1ns;
   timeprecision 1ps;
   wire [2:0] grp = func_bus[6:4];
   wire [3:0] sel = func_bus[3:0];
   wire [1:0] and_m = mem_bus & working_sum & k_bus;
   wire [1:0] k_m = k_bus & mem_bus;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   property p_hold; !clk_en |=> $stable({working_sum, holding_word, carry_out}); endproperty
   a_hold: assert property (p_hold) else $error("state moved while disabled");
   property p_cia; clk_en && grp == 3'h1 && sel == 4'hE && k_bus == 2'h0
      |=> working_sum == 2'(~$past(working_sum) + $past(carry_in)); endproperty
   a_cia: assert property (p_cia) else $error("complement wrong");
   property p_dca; clk_en && grp == 3'h1 && sel == 4'hF && k_bus == 2'h3
      |=> holding_word == 2'($past(holding_word) + 2'h3 + $past(carry_in)); endproperty
   a_dca: assert property (p_dca) else $error("decrement wrong");
   property p_ldi; clk_en && grp == 3'h2 && sel == 4'hE && k_bus == 2'h3
      |=> working_sum == 2'($past(input_bus) + 2'h3 + $past(carry_in)); endproperty
   a_ldi: assert property (p_ldi) else $error("input decrement wrong");
   property p_cset; clk_en && grp == 3'h2 && sel == 4'hD && k_bus == 2'h0
      |=> holding_word == {2{!$past(carry_in)}} && carry_out == $past(carry_in); endproperty
   a_cset: assert property (p_cset) else $error("clear or set wrong");
   property p_aia; clk_en && grp == 3'h3 && sel == 4'hE |=> {carry_out, working_sum} ==
      {1'b0, $past(working_sum)} + ($past(input_bus) & $past(k_bus)) + $past(carry_in); endproperty
   a_aia: assert property (p_aia) else $error("input add wrong");
   property p_anm; clk_en && grp == 3'h4 && sel == 4'hC |=> working_sum == $past(and_m)
      && carry_out == ($past(carry_in) || $past(and_m) != 2'h0); endproperty
   a_anm: assert property (p_anm) else $error("memory and wrong");
   property p_ldm; clk_en && grp == 3'h5 && sel == 4'hD |=> holding_word == $past(k_m)
      && carry_out == ($past(carry_in) || $past(k_m) != 2'h0); endproperty
   a_ldm: assert property (p_ldm) else $error("masked memory load wrong");
   property p_idle; clk_en && (grp == 3'h0 || grp > 3'h5)
      |=> $stable({working_sum, holding_word}) && carry_out == $past(carry_in); endproperty
   a_idle: assert property (p_idle) else $error("idle group changed state");
endmodule // alu_checks

bind bit_slice_alu alu_checks u_checks (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .func_bus(func_bus),
   .k_bus(k_bus), .carry_in(carry_in), .mem_bus(mem_bus), .input_bus(input_bus), .working_sum(working_sum),
   .holding_word(holding_word), .carry_out(carry_out));

// file: test/ctrl_model.sv
// Purpose: Control-unit stand-in for the micro-function inputs.
// Assumes: Called just after a rising ref_clk.
// Notes: Values stay level until the next call.
module ctrl_model (
   // Micro-operation outputs
   output logic [6:0] func_bus,
   output logic [1:0] k_bus,
   output logic carry_in,
   // Data outputs
   output logic [1:0] mem_bus,
   output logic [1:0] input_bus
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {func_bus, k_bus, carry_in, mem_bus, input_bus} = 14'h0000;
   task automatic issue(input logic [6:0] f, input logic [1:0] k, input logic c, input logic [1:0] m,
      input logic [1:0] i);
      {func_bus, k_bus, carry_in, mem_bus, input_bus} = {f, k, c, m, i};
   endtask
endmodule // ctrl_model

// file: test/tb_bit_slice_alu.sv
// Purpose: Self-checking bench for bit_slice_alu.
// Assumes: Seed 47, 40 ns clock.
// Notes: A word-level model predicts every result.
module tb_bit_slice_alu;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk, rst, clk_en, carry_in, carry_out, m_co;
   logic [6:0] func_bus;
   logic [1:0] k_bus, mem_bus, input_bus, working_sum, holding_word;
   logic [1:0] rf [0:11];
   int n_mismatch = 0;
   int tests_run = 0;
   int cycles = 0;
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   bit_slice_alu u_dut (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .func_bus(func_bus), .k_bus(k_bus),
      .carry_in(carry_in), .mem_bus(mem_bus), .input_bus(input_bus), .working_sum(working_sum),
      .holding_word(holding_word), .carry_out(carry_out));
   ctrl_model u_ctrl (.func_bus(func_bus), .k_bus(k_bus), .carry_in(carry_in), .mem_bus(mem_bus),
      .input_bus(input_bus));
   function automatic void predict();
      logic [3:0] s, d;
      logic [1:0] x, y;
      s = func_bus[3:0];
      d = (s == 4'hC || s == 4'hE) ? 4'hB : (s > 4'hB) ? 4'hA : s;
      x = (s < 4'hC) ? rf[s] : (s < 4'hE) ? mem_bus : rf[d];
      y = ((s > 4'hD) ? input_bus : rf[11]) & k_bus;
      m_co = carry_in;
      case (func_bus[6:4])
         3'h1: if (s > 4'hD) {m_co, rf[d]} = {1'b0, ~rf[d] | k_bus} + {1'b0, rf[d] & k_bus} + carry_in;
         3'h2: {m_co, rf[d]} = {1'b0, ((s > 4'hD) ? input_bus : rf[11]) & k_bus} + 3'h3 + carry_in;
         3'h3: {m_co, rf[d]} = {1'b0, x} + {1'b0, y} + carry_in;
         3'h4, 3'h5: begin
            rf[d] = (func_bus[6:4] == 3'h4) ? x & y : x & k_bus;
            m_co = carry_in | (|rf[d]);
         end
         default: ;
      endcase
   endfunction
   task automatic check(input logic [4:0] exp);
      tests_run++;
      if ({carry_out, holding_word, working_sum} !== exp) begin
         n_mismatch++;
         $display("MISMATCH outputs exp %h got %h", exp, {carry_out, holding_word, working_sum});
      end
   endtask
   task automatic step(input logic [6:0] f, input logic [1:0] k, input logic c, input logic [1:0] m,
      input logic [1:0] i, input logic en);
      u_ctrl.issue(f, k, c, m, i);
      clk_en = en;
      #1 if (en) predict();
      @(posedge ref_clk);
      #1 check({m_co, rf[10], rf[11]});
   endtask
   task automatic apply_reset();
      rst = 1'b1;
      repeat (6) @(posedge ref_clk);
      #1 rst = 1'b0;
      foreach (rf[j]) rf[j] = 2'h0;
      m_co = 1'b0;
      check(5'h00);
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 10000) begin
         n_mismatch++;
         test_done();
      end
   end
   initial begin
      rst = 1'b1;
      clk_en = 1'b0;
      void'($urandom(47));
      apply_reset();
      step(7'h5C, 2'h3, 1'b0, 2'h2, 2'h0, 1'b1); // memory load
      step(7'h3E, 2'h3, 1'b0, 2'h0, 2'h1, 1'b1); // input add
      for (int f = 16; f < 96; f++)
         for (int k = 0; k < 8; k++)
            step(7'(f), k[1:0], k[2], 2'($urandom), 2'($urandom), 1'b1); // all forms of groups 1 to 5
      for (int n = 0; n < 3000; n++) begin
         if (n == 1500) apply_reset();
         step(7'($urandom), 2'($urandom), 1'($urandom), 2'($urandom), 2'($urandom), ($urandom % 8) != 0); // random ops
      end
      test_done();
   end
endmodule // tb_bit_slice_alu
